// ===== core/mah_host_top.sv
// Design decisions made here: the address map and the strobed register port.
`timescale 1ns/1ps
module mah_host_top
  import mah_pkg::*;
#(
  parameter int ADDR_W = 4
)(
  input  wire logic              clk,
  input  wire logic              rst_b,
  input  wire logic [ADDR_W-1:0] sw_addr,
  input  wire logic [31:0]       sw_wdata,
  input  wire logic              sw_wr,
  input  wire logic              sw_rd,
  output logic      [31:0]       sw_rdata,
  output logic                   cs_n,
  output logic                   rd_n,
  output logic                   wr_n,
  output logic                   channel_select,
  output logic                   interface_mode,
  input  wire logic              conversion_done_n,
  input  wire logic              host_wait_n,
  input  wire logic [7:0]        result_bus
);

  // ==========================================================
  // reset release
  logic rst_m_r;
  logic rst_sync_b;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_m_r    <= 1'b0;
      rst_sync_b <= 1'b0;
    end else begin
      rst_m_r    <= 1'b1;
      rst_sync_b <= rst_m_r;
    end
  end

  // ==========================================================
  // pin synchroniser
  mah_sync_if sync ();

  mah_pin_sync u_sync (
    .clk        (clk),
    .rst_sync_b (rst_sync_b),
    .done_pin_n (conversion_done_n),
    .wait_pin_n (host_wait_n),
    .result_pin (result_bus),
    .sync       (sync.src)
  );

  // ==========================================================
  // state
  mah_state_e  state_r;
  mah_state_e  state_nxt;
  logic [7:0]  cnt_r;
  logic [7:0]  cnt_nxt;
  logic [7:0]  per_cnt_r;
  logic [2:0]  op_r;
  logic [2:0]  cfg_op_r;
  logic        cfg_chan_r;
  logic        start_pend_r;
  logic        valid_r;
  logic        tmo_r;
  logic        known_r;
  logic        first_done_r;
  logic [1:0]  discard_r;
  logic [7:0]  data_r;
  logic        data_chan_r;
  logic        cap_r;
  logic        cs_n_nxt;
  logic        rd_n_nxt;
  logic        wr_n_nxt;

  wire wr_ctrl    = sw_wr && (sw_addr == ADR_CTRL);
  wire wr_status  = sw_wr && (sw_addr == ADR_STATUS);
  wire rd_data    = sw_rd && (sw_addr == ADR_DATA);
  wire idle       = (state_r == ST_IDLE);
  wire period_ok  = (per_cnt_r == 8'h00);
  wire cnt_last   = (cnt_r == 8'h01);
  wire reduced    = (cfg_op_r == OP_RED);
  // pins tie low only once the mode pin already shows write-then-read
  wire tied       = reduced && interface_mode;
  wire accept     = idle && start_pend_r && period_ok;
  wire done_seen  = !sync.done_n;
  // a done level left low by the last conversion needs the sync depth to flush
  wire done_ok    = done_seen && (cnt_r <= 8'(TIMEOUT_CYC - SYNC_STAGES));
  wire timed_out  = cnt_last && ((state_r == ST_RDWAIT) ||
                    ((state_r == ST_WRWAIT) && (op_r == OP_WRIRQ)));
  wire capture    = ((state_r == ST_RDWAIT) && (done_ok || cnt_last)) ||
                    ((state_r == ST_PIPE) && cnt_last) ||
                    ((state_r == ST_RDLOW) && cnt_last) ||
                    ((state_r == ST_WRWAIT) && (op_r == OP_RED) && cnt_last);
  wire discard    = (op_r == OP_PIPE) && (discard_r != 2'(DISCARD_READS));
  wire keep       = capture && !discard;

  // ==========================================================
  // sequencer
  always_comb begin
    state_nxt = state_r;
    cnt_nxt   = (cnt_r == 8'h00) ? 8'h00 : cnt_r - 8'h01;
    cs_n_nxt  = cs_n;
    rd_n_nxt  = rd_n;
    wr_n_nxt  = wr_n;
    unique case (state_r)
      ST_IDLE: begin
        cs_n_nxt = !tied;
        rd_n_nxt = !tied;
        wr_n_nxt = 1'b1;
        if (accept) begin
          cs_n_nxt  = 1'b0;
          state_nxt = ST_SETUP;
        end
      end
      ST_SETUP: begin
        if (op_r == OP_RD) begin
          rd_n_nxt  = 1'b0;
          cnt_nxt   = 8'(TIMEOUT_CYC);
          state_nxt = ST_RDWAIT;
        end else if (op_r == OP_PIPE) begin
          rd_n_nxt  = 1'b0;
          cnt_nxt   = 8'(PIPE_CYC);
          state_nxt = ST_PIPE;
        end else begin
          wr_n_nxt  = 1'b0;
          cnt_nxt   = 8'(WR_CYC);
          state_nxt = ST_WRLOW;
        end
      end
      ST_RDWAIT: begin
        if (done_ok || cnt_last) begin
          rd_n_nxt  = 1'b1;
          cs_n_nxt  = 1'b1;
          cnt_nxt   = 8'(GAP_CYC);
          state_nxt = ST_GAP;
        end
      end
      ST_PIPE: begin
        if (cnt_last) begin
          rd_n_nxt  = 1'b1;
          cs_n_nxt  = 1'b1;
          cnt_nxt   = 8'(GAP_CYC);
          state_nxt = ST_GAP;
        end
      end
      ST_WRLOW: begin
        if (cnt_last) begin
          wr_n_nxt  = 1'b1;
          state_nxt = ST_WRWAIT;
          unique case (op_r)
            OP_WRIRQ:  cnt_nxt = 8'(TIMEOUT_CYC);
            OP_WRFAST: cnt_nxt = 8'(FAST_CYC);
            default:   cnt_nxt = 8'(RED_CYC);
          endcase
        end
      end
      ST_WRWAIT: begin
        if (op_r == OP_RED) begin
          if (cnt_last) begin
            cnt_nxt   = 8'(GAP_CYC);
            state_nxt = ST_GAP;
          end
        end else if (cnt_last || ((op_r == OP_WRIRQ) && done_seen)) begin
          rd_n_nxt  = 1'b0;
          cnt_nxt   = 8'(RD_ACC_CYC);
          state_nxt = ST_RDLOW;
        end
      end
      ST_RDLOW: begin
        if (cnt_last) begin
          rd_n_nxt  = 1'b1;
          cs_n_nxt  = 1'b1;
          cnt_nxt   = 8'(GAP_CYC);
          state_nxt = ST_GAP;
        end
      end
      ST_GAP: begin
        if (cnt_last) begin
          state_nxt = ST_IDLE;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      state_r <= ST_IDLE;
      cnt_r   <= 8'h00;
      cs_n    <= 1'b1;
      rd_n    <= 1'b1;
      wr_n    <= 1'b1;
    end else begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
      cs_n    <= cs_n_nxt;
      rd_n    <= rd_n_nxt;
      wr_n    <= wr_n_nxt;
    end
  end

  // ==========================================================
  // conversion spacing, channel and mode pins
  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      per_cnt_r      <= 8'h00;
      op_r           <= OP_RD;
      channel_select <= 1'b0;
      interface_mode <= 1'b0;
    end else begin
      if (state_r == ST_SETUP)
        per_cnt_r <= 8'(THRU_CYC);
      else if (!period_ok)
        per_cnt_r <= per_cnt_r - 8'h01;
      if (accept) begin
        op_r           <= cfg_op_r;
        channel_select <= cfg_chan_r;
      end
      // mode pin only moves between conversions, a static level to the converter
      if (idle && !start_pend_r)
        interface_mode <= (cfg_op_r >= OP_WRIRQ);
    end
  end

  // ==========================================================
  // result capture
  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      data_r       <= 8'h00;
      data_chan_r  <= 1'b0;
      known_r      <= 1'b0;
      first_done_r <= 1'b0;
      discard_r    <= 2'h0;
      cap_r        <= 1'b0;
    end else begin
      cap_r <= capture;
      if (capture && discard)
        discard_r <= discard_r + 2'h1;
      if (keep) begin
        data_r       <= sync.result;
        data_chan_r  <= channel_select;
        known_r      <= first_done_r;
        first_done_r <= 1'b1;
      end
    end
  end

  // ==========================================================
  // software registers
  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      cfg_op_r     <= OP_RD;
      cfg_chan_r   <= 1'b0;
      start_pend_r <= 1'b0;
      valid_r      <= 1'b0;
      tmo_r        <= 1'b0;
      sw_rdata     <= 32'h0000_0000;
    end else begin
      if (wr_ctrl) begin
        cfg_chan_r <= sw_wdata[CTRL_CHAN_BIT];
        cfg_op_r   <= sw_wdata[CTRL_OP_LSB +: 3];
      end
      // a new start that lands in the accept cycle stays pending
      if (wr_ctrl && sw_wdata[CTRL_START_BIT])
        start_pend_r <= 1'b1;
      else if (accept)
        start_pend_r <= 1'b0;
      if (keep)
        valid_r <= 1'b1;
      else if (rd_data)
        valid_r <= 1'b0;
      if (timed_out)
        tmo_r <= 1'b1;
      else if (wr_status && sw_wdata[ST_TMO_BIT])
        tmo_r <= 1'b0;
      sw_rdata <= 32'h0000_0000;
      if (sw_rd) begin
        unique case (sw_addr)
          ADR_CTRL:   sw_rdata <= {27'h0, cfg_op_r, cfg_chan_r, start_pend_r};
          ADR_STATUS: sw_rdata <= {27'h0, tmo_r, sync.wait_n, known_r, valid_r, !idle};
          ADR_DATA:   sw_rdata <= {23'h0, data_chan_r, data_r};
          default:    sw_rdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ==========================================================
  // checks
  sequence s_wr_rise;
    $rose(wr_n) && (op_r == OP_RED);
  endsequence

  sequence s_pipe_pulse;
    !rd_n [*6] ##1 rd_n;
  endsequence

  AST_MODE_STATIC: assert property (@(posedge clk) disable iff (!rst_sync_b)
    $changed(interface_mode) |-> $past(idle) && rd_n && wr_n)
    else $error("mode pin moved during a conversion");

  AST_RD_HELD: assert property (@(posedge clk) disable iff (!rst_sync_b)
    (state_r == ST_RDWAIT) && !done_ok && !cnt_last |=> !rd_n)
    else $error("read strobe released before conversion done");

  AST_RD_GAP: assert property (@(posedge clk) disable iff (!rst_sync_b)
    $rose(rd_n) |=> rd_n)
    else $error("read strobe fell again too soon");

  AST_PIPE_WIDTH: assert property (@(posedge clk) disable iff (!rst_sync_b)
    $fell(rd_n) && (op_r == OP_PIPE) |-> s_pipe_pulse)
    else $error("pipelined read pulse width wrong");

  AST_DISCARD: assert property (@(posedge clk) disable iff (!rst_sync_b)
    capture && (op_r == OP_PIPE) && (discard_r < 2'h2) |=> !$rose(valid_r))
    else $error("early pipelined read was kept");

  AST_FAST_READ: assert property (@(posedge clk) disable iff (!rst_sync_b)
    $rose(wr_n) && (op_r == OP_WRFAST) |-> rd_n [*7] ##1 !rd_n)
    else $error("fast read not placed after write strobe");

  AST_THRU: assert property (@(posedge clk) disable iff (!rst_sync_b)
    $fell(wr_n) |-> $past(per_cnt_r) == 8'h00)
    else $error("conversions spaced below throughput period");

  AST_REDUCED: assert property (@(posedge clk) disable iff (!rst_sync_b)
    s_wr_rise |-> (!cs_n && !rd_n) [*6] ##12 cap_r)
    else $error("reduced mode capture timing wrong");

  AST_CHAN_HOLD: assert property (@(posedge clk) disable iff (!rst_sync_b)
    $changed(channel_select) |-> $past(rd_n || reduced) && $past(wr_n) && cs_n == 1'b0)
    else $error("channel changed while a strobe was low");

endmodule

// ===== core/mah_pin_sync.sv
`timescale 1ns/1ps
module mah_pin_sync
  import mah_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_sync_b,
  input  wire logic       done_pin_n,
  input  wire logic       wait_pin_n,
  input  wire logic [7:0] result_pin,
  mah_sync_if.src         sync
);

  // ==========================================================
  // two-stage synchroniser, first stage read only by the second
  logic [9:0] stage1_r;
  logic [9:0] stage2_r;

  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      stage1_r <= 10'h300;
      stage2_r <= 10'h300;
    end else begin
      stage1_r <= {done_pin_n, wait_pin_n, result_pin};
      stage2_r <= stage1_r;
    end
  end

  assign sync.done_n = stage2_r[9];
  assign sync.wait_n = stage2_r[8];
  assign sync.result = stage2_r[7:0];

endmodule

// ===== core/mah_pkg.sv
package mah_pkg;

  // ==========================================================
  // clock and timing
  localparam int CLK_PERIOD_PS = 50000;
  localparam int SYNC_STAGES   = 2;

  function automatic int ns_up(input int ns);
    int c;
    c = (ns * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    return (c < 1) ? 1 : c;
  endfunction

  function automatic int ns_dn(input int ns);
    int c;
    c = (ns * 1000) / CLK_PERIOD_PS;
    return (c < 1) ? 1 : c;
  endfunction

  localparam int RD_GAP_NS     = 50;
  localparam int PIPE_MIN_NS   = 200;
  localparam int PIPE_MAX_NS   = 400;
  localparam int PIPE_RD_NS    = 300;
  localparam int WR_LOW_NS     = 100;
  localparam int INT_MAX_NS    = 520;
  localparam int FAST_RD_NS    = 350;
  localparam int RD_ACCESS_NS  = 100;
  localparam int THRU_NS       = 660;
  localparam int REDUCED_NS    = 705;

  localparam int GAP_CYC       = ns_up(RD_GAP_NS);
  localparam int PIPE_MIN_CYC  = ns_up(PIPE_MIN_NS);
  localparam int PIPE_MAX_CYC  = ns_dn(PIPE_MAX_NS);
  localparam int PIPE_CYC      = ns_up(PIPE_RD_NS);
  localparam int WR_CYC        = ns_up(WR_LOW_NS);
  localparam int INT_MAX_CYC   = ns_dn(INT_MAX_NS);
  localparam int FAST_CYC      = ns_up(FAST_RD_NS);
  localparam int RD_ACC_CYC    = ns_up(RD_ACCESS_NS) + SYNC_STAGES;
  localparam int THRU_CYC      = ns_up(THRU_NS);
  localparam int RED_CYC       = ns_up(REDUCED_NS) + SYNC_STAGES;
  localparam int TIMEOUT_CYC   = 64;
  localparam int DISCARD_READS = 2;

  // ==========================================================
  // register map
  localparam logic [3:0] ADR_CTRL   = 4'h0;
  localparam logic [3:0] ADR_STATUS = 4'h4;
  localparam logic [3:0] ADR_DATA   = 4'h8;

  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_CHAN_BIT  = 1;
  localparam int CTRL_OP_LSB    = 2;
  localparam int ST_BUSY_BIT    = 0;
  localparam int ST_VALID_BIT   = 1;
  localparam int ST_KNOWN_BIT   = 2;
  localparam int ST_WAIT_BIT    = 3;
  localparam int ST_TMO_BIT     = 4;
  localparam int DATA_CHAN_BIT  = 8;

  localparam logic [2:0] OP_RD     = 3'h0;
  localparam logic [2:0] OP_PIPE   = 3'h1;
  localparam logic [2:0] OP_WRIRQ  = 3'h2;
  localparam logic [2:0] OP_WRFAST = 3'h3;
  localparam logic [2:0] OP_RED    = 3'h4;

  typedef enum logic [7:0] {
    ST_IDLE   = 8'h01,
    ST_SETUP  = 8'h02,
    ST_RDWAIT = 8'h04,
    ST_PIPE   = 8'h08,
    ST_WRLOW  = 8'h10,
    ST_WRWAIT = 8'h20,
    ST_RDLOW  = 8'h40,
    ST_GAP    = 8'h80
  } mah_state_e;

endpackage

// ===== core/mah_sync_if.sv
`timescale 1ns/1ps
interface mah_sync_if;
  logic       done_n;
  logic       wait_n;
  logic [7:0] result;
  modport src (output done_n, output wait_n, output result);
  modport dst (input done_n, input wait_n, input result);
endinterface

// ===== test/mah_conv_model.sv
`timescale 1ns/1ps
// ==========
// converter model: no clock, timing by delays
module mah_conv_model #(
  parameter int T_RD   = 600,
  parameter int T_INT  = 450,
  parameter int T_SLOW = 4000
)(
  input  wire logic       cs_n,
  input  wire logic       rd_n,
  input  wire logic       wr_n,
  input  wire logic       channel_select,
  input  wire logic       interface_mode,
  input  wire logic       slow,
  input  wire logic [7:0] ain0,
  input  wire logic [7:0] ain1,
  output logic            conversion_done_n,
  output logic            host_wait_n,
  output logic      [7:0] result_bus
);
  logic [7:0] last_r  = 8'h5a;
  logic [7:0] shown_r = 8'h5a;
  logic [7:0] pend_r  = 8'h00;
  logic       busy    = 1'b0;
  int         gen     = 0;
  initial begin
    conversion_done_n = 1'b1;
    host_wait_n = 1'b1;
  end
  // released bus shows the inverse, so a late sample cannot pass
  assign result_bus = (!cs_n && !rd_n) ? shown_r : ~shown_r;
  // estimator guess, one-step correction, then two flash passes
  function automatic logic [7:0] multistep(input logic [7:0] x);
    logic [5:0] therm;
    logic [2:0] ones;
    logic [1:0] est;
    therm = {x >= 8'hd0, x >= 8'hb0, x >= 8'h90, x >= 8'h70, x >= 8'h50, x >= 8'h30};
    ones = 3'($countones(therm));
    est = (ones >= 3'h5) ? 2'h3 : 2'((ones + 3'h1) >> 1);
    if (x[7:6] < est)
      est = est - 2'h1;
    return {est, x[5:3], x[2:0]};
  endfunction
  task automatic latch_in;
    pend_r = multistep(channel_select ? ain1 : ain0);
    conversion_done_n = 1'b1;
    busy = 1'b1;
    gen++;
  endtask
  task automatic done_conv;
    last_r = pend_r;
    busy = 1'b0;
    gen++;
    host_wait_n = 1'b1;
    conversion_done_n = 1'b0;
    if (!rd_n && !cs_n)
      shown_r = last_r;
  endtask
  // a newer start or an early read bumps gen and cancels this finish
  task automatic sched(input int dly);
    int g;
    g = gen;
    fork
      begin
        #(dly + (slow ? T_SLOW : 0));
        if (g == gen)
          done_conv();
      end
    join_none
  endtask
  always @(negedge cs_n) host_wait_n = 1'b0;
  always @(negedge rd_n) begin
    if (!cs_n && !interface_mode) begin
      shown_r = last_r;
      latch_in();
      sched(T_RD);
    end else if (!cs_n && busy) begin
      done_conv();
    end else begin
      shown_r = last_r;
    end
  end
  always @(posedge rd_n) conversion_done_n = 1'b1;
  always @(negedge wr_n) if (!cs_n && interface_mode) latch_in();
  always @(posedge wr_n) if (busy && interface_mode) sched(T_INT);
endmodule

// ===== test/mah_host_top_bench.sv
`timescale 1ns/1ps
module mah_host_top_bench
  import mah_pkg::*;
;
  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic [3:0]  sw_addr = 4'h0;
  logic [31:0] sw_wdata = 32'h0;
  logic        sw_wr = 1'b0;
  logic        sw_rd = 1'b0;
  logic        slow = 1'b0;
  logic [7:0]  a0 = 8'h00;
  logic [7:0]  a1 = 8'h00;
  logic [31:0] sw_rdata;
  logic        cs_n, rd_n, wr_n, channel_select, interface_mode;
  logic        conversion_done_n, host_wait_n;
  logic [7:0]  result_bus;
  logic [31:0] rnd = 32'hf42d8d08;
  logic [7:0]  prev = 8'h00;
  logic [2:0]  cur_op = 3'h7;
  logic        ch_lat = 1'b0;
  realtime     t_rdr = 0, t_wrr = 0, t_rdf = 0, t_st = -1000;
  int          err_count = 0, check_count = 0, cyc = 0;

  initial forever #25 clk = ~clk;

  mah_host_top dut (.clk(clk), .rst_b(rst_b), .sw_addr(sw_addr), .sw_wdata(sw_wdata),
    .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata), .cs_n(cs_n), .rd_n(rd_n),
    .wr_n(wr_n), .channel_select(channel_select), .interface_mode(interface_mode),
    .conversion_done_n(conversion_done_n), .host_wait_n(host_wait_n),
    .result_bus(result_bus));
  mah_conv_model conv_dev (.cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n), .slow(slow),
    .channel_select(channel_select), .interface_mode(interface_mode), .ain0(a0),
    .ain1(a1), .conversion_done_n(conversion_done_n), .host_wait_n(host_wait_n),
    .result_bus(result_bus));

  // ==========
  // helpers
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [31:0] exp_data(input logic ch, input logic [7:0] x, y);
    return {23'h0, ch, ch ? y : x};
  endfunction
  function automatic logic [2:0] op_of(input logic [1:0] k);
    return k == 2'h0 ? OP_RD : k == 2'h1 ? OP_WRIRQ : k == 2'h2 ? OP_WRFAST : OP_RED;
  endfunction
  task automatic chk(input string nm, input logic [31:0] e, g);
    check_count++;
    if (g !== e) begin
      err_count++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic ok(input string nm, input logic c);
    chk(nm, 32'h1, {31'h0, c});
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    sw_addr <= a;
    sw_wdata <= d;
    sw_wr <= 1'b1;
    @(posedge clk);
    sw_wr <= 1'b0;
  endtask
  // data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk);
    sw_addr <= a;
    sw_rd <= 1'b1;
    @(posedge clk);
    sw_rd <= 1'b0;
    @(negedge clk);
    d = sw_rdata;
  endtask
  task automatic conv(input logic [2:0] op, input logic ch, input logic keep, known);
    logic [31:0] d;
    logic [31:0] st;
    logic [31:0] e;
    int n;
    rnd = lfsr(rnd);
    e = exp_data(ch, rnd[7:0], rnd[15:8]);
    cur_op = op;
    wr(ADR_CTRL, {27'h0, op, ch, 1'b0});
    a0 <= rnd[7:0];
    a1 <= rnd[15:8];
    repeat (2) @(posedge clk);
    ok("mode pin", interface_mode === (op >= OP_WRIRQ));
    wr(ADR_CTRL, {27'h0, op, ch, 1'b1});
    n = 0;
    do begin
      rd(ADR_CTRL, d);
      rd(ADR_STATUS, st);
      if (n == 0 && op != OP_RED && st[ST_BUSY_BIT])
        chk("wait low", 32'h0, {31'h0, st[ST_WAIT_BIT]});
      n++;
    end while ((d[0] || st[0]) && n < 200);
    chk("valid", {31'h0, keep}, {31'h0, st[ST_VALID_BIT]});
    if (keep) begin
      chk("known", {31'h0, known}, {31'h0, st[ST_KNOWN_BIT]});
      rd(ADR_DATA, d);
      if (op == OP_PIPE)
        chk("pipe data", {24'h0, prev}, {24'h0, d[7:0]});
      else
        chk("data", e, d);
      rd(ADR_STATUS, st);
      chk("valid clear", 32'h0, {31'h0, st[ST_VALID_BIT]});
    end
    if (op == OP_RED)
      ok("tied pins", !cs_n && !rd_n);
    prev = e[7:0];
  endtask
  task stop_test;
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // ==========
  // pin timing monitors
  always @(negedge rd_n) begin
    if (cur_op != OP_RED && t_rdr > 0)
      ok("rd gap", $realtime - t_rdr >= 50);
    if (cur_op == OP_WRFAST)
      ok("fast rd", $realtime - t_wrr >= 350);
    if (cur_op < OP_WRIRQ) begin
      ok("spacing", $realtime - t_st >= 660);
      t_st = $realtime;
      ch_lat = channel_select;
    end
    t_rdf = $realtime;
  end
  always @(posedge rd_n) begin
    if (cur_op == OP_PIPE)
      ok("pipe width", ($realtime - t_rdf >= 200) && ($realtime - t_rdf <= 400));
    t_rdr = $realtime;
  end
  always @(negedge wr_n) begin
    ok("spacing", $realtime - t_st >= 660);
    t_st = $realtime;
    ch_lat = channel_select;
  end
  always @(posedge wr_n) t_wrr = $realtime;
  // channel may move only with wr_n high, and with rd_n high too in the read modes
  always @(posedge clk)
    if (rst_b && (!wr_n || (!rd_n && cur_op < OP_WRIRQ)) && channel_select !== ch_lat)
      ok("chan hold", 1'b0);
  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      err_count++;
      stop_test();
    end
  end

  // ==========
  // main sequence
  initial begin
    logic [31:0] d;
    repeat (8) @(posedge clk);
    ok("reset pins", cs_n & rd_n & wr_n & !channel_select & !interface_mode);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk);
    rd(ADR_CTRL, d);
    chk("ctrl reset", 32'h0, d);
    rd(ADR_STATUS, d);
    chk("status reset", 32'h8, d);
    rd(ADR_DATA, d);
    chk("data reset", 32'h0, d);
    wr(4'hc, 32'hffffffff);
    rd(4'hc, d);
    chk("unmapped", 32'h0, d);
    for (int i = 0; i < 3; i++)
      conv(OP_PIPE, rnd[16], i == 2, 1'b0);
    for (int i = 0; i < 4; i++)
      conv(op_of(i[1:0]), rnd[16], 1'b1, 1'b1);
    for (int i = 0; i < 12; i++)
      conv(op_of(rnd[1:0]), rnd[16], 1'b1, 1'b1);
    slow <= 1'b1;
    conv(OP_WRIRQ, rnd[16], 1'b1, 1'b1);
    rd(ADR_STATUS, d);
    chk("timeout", 32'h1, {31'h0, d[ST_TMO_BIT]});
    wr(ADR_STATUS, 32'h10);
    rd(ADR_STATUS, d);
    chk("timeout clear", 32'h0, {31'h0, d[ST_TMO_BIT]});
    stop_test();
  end
endmodule
